// ---- design/buffered_i2c_master_engine.sv ----
`timescale 1ns/1ps
`default_nettype none
module buffered_i2c_master_engine #(
	parameter int unsigned FIFO_DEPTH_P = i2c_engine_pkg::FIFO_DEPTH
) (
	// clock and reset
	input  wire logic                               i_clk_sys,
	input  wire logic                               i_rst,
	// configuration
	input  wire logic [i2c_engine_pkg::DIV_W-1:0]   i_scl_divider_count,
	input  wire logic                               i_pin_pair_select,
	input  wire logic                               i_ten_bit_address_select,
	input  wire logic [i2c_engine_pkg::LEN_W-1:0]   i_first_burst_length,
	input  wire logic                               i_first_burst_direction,
	input  wire logic                               i_repeated_start_enable,
	input  wire logic [i2c_engine_pkg::LEN_W-1:0]   i_second_burst_length,
	input  wire logic                               i_second_burst_direction,
	input  wire logic                               i_stop_enable,
	// start or resume
	input  wire logic                               i_target_address_trigger,
	input  wire logic [i2c_engine_pkg::ADDR_W-1:0]  i_target_address,
	// write buffer loading
	input  wire logic                               i_tx_buffer_write,
	input  wire logic                               i_tx_buffer_pointer_load,
	input  wire logic [i2c_engine_pkg::PTR_W-1:0]   i_tx_buffer_pointer,
	input  wire logic [7:0]                         i_tx_buffer_data,
	output logic                                    o_tx_buffer_ready,
	// read buffer access
	input  wire logic [i2c_engine_pkg::PTR_W-1:0]   i_rx_buffer_pointer,
	output logic [7:0]                              o_rx_buffer_data,
	// status
	output logic                                    o_transaction_complete_flag,
	output logic                                    o_paused_waiting_flag,
	output logic                                    o_attention_pulse,
	// bus pins, two open-drain pairs
	input  wire logic [1:0]                         i_scl_in,
	input  wire logic [1:0]                         i_sda_in,
	output logic [1:0]                              o_scl_out,
	output logic [1:0]                              o_scl_oe_n,
	output logic [1:0]                              o_sda_out,
	output logic [1:0]                              o_sda_oe_n
);
	import i2c_engine_pkg::*;

	engine_state_e     state, next_state;
	logic [1:0]        quarter, next_quarter;
	logic [DIV_W-1:0]  tick, next_tick;
	logic [3:0]        bit_idx, next_bit_idx;
	logic [7:0]        shreg, next_shreg;
	logic [1:0]        hdr_left, next_hdr_left;
	logic              seg, next_seg;
	logic              dir, next_dir;
	logic [LEN_W-1:0]  len_left, next_len_left;
	logic [PTR_W-1:0]  tx_ptr, next_tx_ptr;
	logic [PTR_W-1:0]  rx_ptr, next_rx_ptr;
	logic [PTR_W-1:0]  wr_ptr, next_wr_ptr;
	logic              pair, next_pair;
	logic [ADDR_W-1:0] addr, next_addr;
	logic              ten, next_ten;
	logic              use_sr, next_use_sr;
	logic              complete, next_complete;
	logic              paused, next_paused;
	logic              attn, next_attn;
	logic              scl_lvl, sda_lvl;
	logic [DIV_W-1:0]  div_eff;
	logic              q_end, bit_end, byte_start, byte_end, accept;
	logic              rx_we;
	logic              nack;
	logic              fifo_valid, fifo_pop, fifo_load;
	logic [FIFO_W-1:0] fifo_data;
	logic [PTR_W-1:0]  fifo_addr;
	logic [7:0]        tx_rdata;

	// host writes pass through a small queue; it drains only while the engine is idle or paused in hold
	byte_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_DEPTH_P)) u_load_fifo (
		.i_clk_sys   (i_clk_sys),
		.i_rst       (i_rst),
		.i_in_valid  (i_tx_buffer_write),
		.i_in_data   ({i_tx_buffer_pointer_load, i_tx_buffer_pointer, i_tx_buffer_data}),
		.o_in_ready  (o_tx_buffer_ready),
		.o_out_valid (fifo_valid),
		.o_out_data  (fifo_data),
		.i_out_ready (fifo_pop)
	);

	assign fifo_pop  = fifo_valid && (state == ST_IDLE || state == ST_HOLD);
	assign fifo_load = fifo_data[FIFO_W-1];
	assign fifo_addr = fifo_load ? fifo_data[FIFO_W-2 -: PTR_W] : wr_ptr;
	assign next_wr_ptr = fifo_pop ? PTR_W'(fifo_addr + 1'b1) : wr_ptr;

	byte_buffer_mem #(.DEPTH(BUF_DEPTH), .AW(PTR_W)) u_tx_buf (
		.i_clk_sys (i_clk_sys),
		.i_wr_en   (fifo_pop),
		.i_wr_addr (fifo_addr),
		.i_wr_data (fifo_data[7:0]),
		.i_rd_addr (next_tx_ptr),
		.o_rd_data (tx_rdata)
	);

	byte_buffer_mem #(.DEPTH(BUF_DEPTH), .AW(PTR_W)) u_rx_buf (
		.i_clk_sys (i_clk_sys),
		.i_wr_en   (rx_we),
		.i_wr_addr (rx_ptr),
		.i_wr_data (shreg),
		.i_rd_addr (i_rx_buffer_pointer),
		.o_rd_data (o_rx_buffer_data)
	);

	// a divider of one would let data and clock edges collide
	assign div_eff    = (i_scl_divider_count < MIN_DIVIDER) ? MIN_DIVIDER : i_scl_divider_count;
	// at or past the end, so a divider lowered mid-quarter cannot run the count away
	assign q_end      = (tick >= DIV_W'(div_eff - 1'b1));
	assign bit_end    = q_end && (quarter == LAST_QUARTER);
	assign byte_start = (state == ST_BYTE) && (bit_idx == '0) && (quarter == '0) && (tick == '0);
	assign byte_end   = (state == ST_BYTE) && (bit_idx == ACK_BIT) && bit_end;
	assign accept     = i_target_address_trigger && (state == ST_IDLE || state == ST_HOLD);
	assign nack       = (len_left == LEN_ONE) && (i_stop_enable || (!seg && use_sr));
	assign rx_we      = (state == ST_BYTE) && dir && (hdr_left == '0) && (bit_idx == ACK_BIT)
		&& (quarter == '0) && (tick == '0);

	// bus levels for the current phase
	always_comb begin
		scl_lvl = 1'b1;
		sda_lvl = 1'b1;
		case (state)
			ST_IDLE: begin
				scl_lvl = 1'b1;
				sda_lvl = 1'b1;
			end
			ST_START: begin
				scl_lvl = (quarter == 2'h1) || (quarter == 2'h2);
				sda_lvl = !quarter[1];
			end
			ST_BYTE: begin
				scl_lvl = (quarter == 2'h1) || (quarter == 2'h2);
				if (bit_idx != ACK_BIT) begin
					sda_lvl = (dir && hdr_left == '0) ? 1'b1 : shreg[7];
				end else begin
					sda_lvl = (dir && hdr_left == '0) ? nack : 1'b1;
				end
			end
			ST_STOP: begin
				scl_lvl = (quarter != '0);
				sda_lvl = quarter[1];
			end
			ST_HOLD: begin
				scl_lvl = 1'b0;
				sda_lvl = 1'b1;
			end
			default: begin
				scl_lvl = 1'b1;
				sda_lvl = 1'b1;
			end
		endcase
	end

	function automatic logic [7:0] header_byte(input logic [1:0] left, input logic t,
		input logic [ADDR_W-1:0] a, input logic d);
		if (!t) begin
			header_byte = {a[6:0], d};
		end else if (left == 2'h2) begin
			header_byte = {TEN_BIT_PREFIX, a[9:8], d};
		end else begin
			header_byte = a[7:0];
		end
	endfunction

	always_comb begin
		next_state    = state;
		next_quarter  = quarter;
		next_tick     = tick;
		next_bit_idx  = bit_idx;
		next_shreg    = shreg;
		next_hdr_left = hdr_left;
		next_seg      = seg;
		next_dir      = dir;
		next_len_left = len_left;
		next_tx_ptr   = tx_ptr;
		next_rx_ptr   = rx_ptr;
		next_pair     = pair;
		next_addr     = addr;
		next_ten      = ten;
		next_use_sr   = use_sr;
		next_complete = complete;
		next_paused   = paused;
		next_attn     = 1'b0;
		if (state != ST_IDLE && state != ST_HOLD) begin
			next_tick = q_end ? '0 : DIV_W'(tick + 1'b1);
			if (q_end) begin
				next_quarter = 2'(quarter + 1'b1);
			end
		end
		if (accept) begin
			next_complete = 1'b0;
			next_paused   = 1'b0;
			next_addr     = i_target_address;
			next_tx_ptr   = PTR_ZERO;
			next_rx_ptr   = PTR_ZERO;
			next_tick     = '0;
			next_quarter  = '0;
			next_bit_idx  = '0;
			if (state == ST_IDLE) begin
				next_state    = ST_START;
				next_pair     = i_pin_pair_select;
				next_ten      = i_ten_bit_address_select;
				next_use_sr   = i_repeated_start_enable;
				next_seg      = 1'b0;
				next_dir      = i_first_burst_direction;
				next_len_left = i_first_burst_length;
				next_hdr_left = i_ten_bit_address_select ? 2'h2 : 2'h1;
			end else begin
				// resume the paused burst with a fresh buffer
				next_state = ST_BYTE;
				if (len_left == '0) begin
					next_len_left = seg ? i_second_burst_length : i_first_burst_length;
				end
			end
		end
		case (state)
			ST_START: begin
				if (bit_end) begin
					next_state   = ST_BYTE;
					next_bit_idx = '0;
				end
			end
			ST_BYTE: begin
				if (byte_start) begin
					next_shreg = (hdr_left != '0) ? header_byte(hdr_left, ten, addr, dir)
						: (dir ? RELEASED_BYTE : tx_rdata);
				end
				if (dir && hdr_left == '0 && quarter == SAMPLE_QUARTER && q_end && bit_idx != ACK_BIT) begin
					next_shreg = {shreg[6:0], i_sda_in[pair]};
				end
				if (!(dir && hdr_left == '0) && bit_end && bit_idx != ACK_BIT) begin
					next_shreg = {shreg[6:0], 1'b0};
				end
				if (rx_we) begin
					next_rx_ptr = PTR_W'(rx_ptr + 1'b1);
				end
				if (!dir && hdr_left == '0 && bit_idx == ACK_BIT && quarter == '0 && tick == '0) begin
					next_tx_ptr = PTR_W'(tx_ptr + 1'b1);
				end
				if (bit_end) begin
					next_bit_idx = 4'(bit_idx + 1'b1);
				end
				if (byte_end) begin
					next_bit_idx = '0;
					if (hdr_left != '0) begin
						next_hdr_left = 2'(hdr_left - 1'b1);
					end else begin
						next_len_left = LEN_W'(len_left - 1'b1);
					end
					// a full buffer without stop means the host must service it
					if (hdr_left == '0 && !i_stop_enable && len_left != LEN_ONE
						&& (dir ? rx_ptr : tx_ptr) == PTR_ZERO) begin
						next_state  = ST_HOLD;
						next_paused = 1'b1;
						next_attn   = 1'b1;
					end else if ((hdr_left == '0 && len_left == LEN_ONE) || (hdr_left == 2'h1 && len_left == '0)) begin
						if (!seg && use_sr) begin
							next_state    = ST_START;
							next_seg      = 1'b1;
							next_dir      = i_second_burst_direction;
							next_len_left = i_second_burst_length;
							next_hdr_left = ten ? 2'h2 : 2'h1;
						end else if (i_stop_enable) begin
							next_state = ST_STOP;
						end else begin
							next_state    = ST_HOLD;
							next_paused   = 1'b1;
							next_attn     = 1'b1;
							next_len_left = '0;
						end
					end
				end
			end
			ST_STOP: begin
				if (bit_end) begin
					next_state    = ST_IDLE;
					next_complete = 1'b1;
					next_attn     = 1'b1;
				end
			end
			ST_IDLE, ST_HOLD: begin
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			state    <= ST_IDLE;
			quarter  <= '0;
			tick     <= '0;
			bit_idx  <= '0;
			shreg    <= '0;
			hdr_left <= '0;
			seg      <= 1'b0;
			dir      <= 1'b0;
			len_left <= '0;
			tx_ptr   <= '0;
			rx_ptr   <= '0;
			wr_ptr   <= '0;
			pair     <= 1'b0;
			addr     <= '0;
			ten      <= 1'b0;
			use_sr   <= 1'b0;
			complete <= 1'b1;
			paused   <= 1'b0;
			attn     <= 1'b0;
		end else begin
			state    <= next_state;
			quarter  <= next_quarter;
			tick     <= next_tick;
			bit_idx  <= next_bit_idx;
			shreg    <= next_shreg;
			hdr_left <= next_hdr_left;
			seg      <= next_seg;
			dir      <= next_dir;
			len_left <= next_len_left;
			tx_ptr   <= next_tx_ptr;
			rx_ptr   <= next_rx_ptr;
			wr_ptr   <= next_wr_ptr;
			pair     <= next_pair;
			addr     <= next_addr;
			ten      <= next_ten;
			use_sr   <= next_use_sr;
			complete <= next_complete;
			paused   <= next_paused;
			attn     <= next_attn;
		end
	end

	assign o_transaction_complete_flag = complete;
	assign o_paused_waiting_flag       = paused;
	assign o_attention_pulse           = attn;

	// open drain: only the selected pair is ever pulled low
	for (genvar p = 0; p < 2; p++) begin : g_pair
		always_ff @(posedge i_clk_sys) begin
			if (i_rst) begin
				o_scl_out[p]  <= 1'b0;
				o_sda_out[p]  <= 1'b0;
				o_scl_oe_n[p] <= 1'b1;
				o_sda_oe_n[p] <= 1'b1;
			end else begin
				o_scl_out[p]  <= 1'b0;
				o_sda_out[p]  <= 1'b0;
				o_scl_oe_n[p] <= (pair == 1'(p)) ? scl_lvl : 1'b1;
				o_sda_oe_n[p] <= (pair == 1'(p)) ? sda_lvl : 1'b1;
			end
		end
	end

	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);

	chk_start_clears_done: assert property (accept |=> !complete) else $error("complete not cleared");
	chk_stop_sets_done: assert property (state == ST_STOP && bit_end |=> complete && state == ST_IDLE && attn)
		else $error("stop did not complete");
	chk_tick_in_range: assert property (tick < div_eff || $changed(i_scl_divider_count))
		else $error("divider overrun");
	chk_unselected_pair_idle: assert property (##1 o_scl_oe_n[!pair] && o_sda_oe_n[!pair])
		else $error("unselected pair driven");
	chk_hold_sets_paused: assert property ($rose(state == ST_HOLD) |-> paused && attn)
		else $error("hold without flag");
	chk_ptr_auto_inc: assert property (fifo_pop && !fifo_load
		|=> wr_ptr == PTR_W'($past(wr_ptr) + 1'b1)) else $error("pointer did not advance");
	chk_ptr_load: assert property (fifo_pop && fifo_load
		|=> wr_ptr == PTR_W'($past(fifo_data[FIFO_W-2 -: PTR_W]) + 1'b1)) else $error("pointer load wrong");
	chk_last_read_nack: assert property (state == ST_BYTE && dir && hdr_left == '0 && bit_idx == ACK_BIT
		&& len_left == LEN_ONE && i_stop_enable |-> sda_lvl) else $error("last byte acknowledged");
	chk_ten_bit_header: assert property (byte_start && ten && hdr_left == 2'h2
		|=> shreg[7:3] == TEN_BIT_PREFIX) else $error("bad ten bit header");
	chk_scl_high_quarters: assert property (state == ST_BYTE && quarter == 2'h1 |-> ##1 o_scl_oe_n[pair])
		else $error("scl pulled low in high phase");

	cov_write_done: cover property (accept && !i_first_burst_direction ##[1:1000] $rose(complete));
	cov_read_done: cover property (rx_we ##[1:1000] $rose(complete));
	cov_repeated_start: cover property (seg && state == ST_START);
	cov_pause_resume: cover property (state == ST_HOLD ##[1:1000] accept);
endmodule
`default_nettype wire

// ---- design/byte_buffer_mem.sv ----
`timescale 1ns/1ps
`default_nettype none
module byte_buffer_mem #(
	parameter int unsigned DEPTH = 16,
	parameter int unsigned AW    = 4
) (
	// clock
	input  wire logic          i_clk_sys,
	// write port
	input  wire logic          i_wr_en,
	input  wire logic [AW-1:0] i_wr_addr,
	input  wire logic [7:0]    i_wr_data,
	// registered read port
	input  wire logic [AW-1:0] i_rd_addr,
	output logic [7:0]         o_rd_data
);
	logic [7:0] cells [DEPTH];

	always_ff @(posedge i_clk_sys) begin
		if (i_wr_en) begin
			cells[i_wr_addr] <= i_wr_data;
		end
		o_rd_data <= cells[i_rd_addr];
	end
endmodule
`default_nettype wire

// ---- design/byte_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
	parameter int unsigned WIDTH = 13,
	parameter int unsigned DEPTH = 8
) (
	// clock and reset
	input  wire logic             i_clk_sys,
	input  wire logic             i_rst,
	// fill side
	input  wire logic             i_in_valid,
	input  wire logic [WIDTH-1:0] i_in_data,
	output logic                  o_in_ready,
	// drain side
	output logic                  o_out_valid,
	output logic [WIDTH-1:0]      o_out_data,
	input  wire logic             i_out_ready
);
	localparam int unsigned AW = $clog2(DEPTH);
	logic [WIDTH-1:0] store [DEPTH];
	logic [AW-1:0]    wr_idx;
	logic [AW-1:0]    rd_idx;
	logic [AW:0]      count;
	logic [AW-1:0]    next_wr_idx;
	logic [AW-1:0]    next_rd_idx;
	logic [AW:0]      next_count;
	logic             push;
	logic             pop;

	always_comb begin
		push        = i_in_valid && o_in_ready;
		pop         = o_out_valid && i_out_ready;
		next_wr_idx = push ? AW'(wr_idx + 1'b1) : wr_idx;
		next_rd_idx = pop ? AW'(rd_idx + 1'b1) : rd_idx;
		next_count  = count;
		if (push && !pop) begin
			next_count = (AW+1)'(count + 1'b1);
		end else if (pop && !push) begin
			next_count = (AW+1)'(count - 1'b1);
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			wr_idx      <= '0;
			rd_idx      <= '0;
			count       <= '0;
			o_in_ready  <= 1'b1;
			o_out_valid <= 1'b0;
		end else begin
			wr_idx      <= next_wr_idx;
			rd_idx      <= next_rd_idx;
			count       <= next_count;
			o_in_ready  <= (next_count != (AW+1)'(DEPTH));
			o_out_valid <= (next_count != '0);
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (push) begin
			store[wr_idx] <= i_in_data;
		end
	end

	assign o_out_data = store[rd_idx];
endmodule
`default_nettype wire

// ---- design/i2c_engine_pkg.sv ----
package i2c_engine_pkg;
	localparam int unsigned SYS_CLK_HZ      = 10_000_000;
	localparam int unsigned STD_SCL_HZ      = 100_000;
	localparam int unsigned FAST_SCL_HZ     = 400_000;
	localparam int unsigned QUARTERS        = 4;
	// divider counts that keep the bus at or below each nominal rate
	localparam int unsigned STD_DIVIDER     = (SYS_CLK_HZ + QUARTERS * STD_SCL_HZ - 1) / (QUARTERS * STD_SCL_HZ);
	localparam int unsigned FAST_DIVIDER    = (SYS_CLK_HZ + QUARTERS * FAST_SCL_HZ - 1) / (QUARTERS * FAST_SCL_HZ);
	localparam int unsigned DIV_W           = 8;
	localparam logic [7:0]  MIN_DIVIDER     = 8'h02;
	localparam int unsigned BUF_DEPTH       = 16;
	localparam int unsigned PTR_W           = 4;
	localparam int unsigned LEN_W           = 5;
	localparam int unsigned ADDR_W          = 10;
	localparam int unsigned FIFO_DEPTH      = 8;
	localparam int unsigned FIFO_W          = 1 + PTR_W + 8;
	localparam logic [4:0]  TEN_BIT_PREFIX  = 5'h1E;
	localparam logic [3:0]  ACK_BIT         = 4'h8;
	localparam logic [1:0]  LAST_QUARTER    = 2'h3;
	localparam logic [1:0]  SAMPLE_QUARTER  = 2'h2;
	localparam logic [7:0]  RELEASED_BYTE   = 8'hFF;
	localparam logic [3:0]  PTR_ZERO        = 4'h0;
	localparam logic [3:0]  PTR_LAST        = 4'hF;
	localparam logic [4:0]  LEN_ONE         = 5'h01;

	typedef enum logic [4:0] {
		ST_IDLE  = 5'h01,
		ST_START = 5'h02,
		ST_BYTE  = 5'h04,
		ST_STOP  = 5'h08,
		ST_HOLD  = 5'h10
	} engine_state_e;
endpackage

// ---- tb/i2c_target_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module i2c_target_model #(
	parameter logic [7:0] RD_BASE = 8'hA0
) (
	// bus wires after the pull-ups
	input  wire logic i_scl,
	input  wire logic i_sda,
	// data pull-down, 0 = pulling low
	output logic      o_sda_oe_n
);
	logic [7:0] sh = 8'h00;
	logic [7:0] cur;
	logic [7:0] log_q[$];
	logic       ack_q[$];
	int         bitn = 0;
	int         starts = 0;
	int         stops = 0;
	int         rd_idx = 0;
	bit         rd = 0;
	bit         first = 0;
	time        t0 = 0;
	time        per = 0;

	initial o_sda_oe_n = 1'b1;

	function automatic void clear();
		log_q.delete();
		ack_q.delete();
		starts = 0;
		stops = 0;
	endfunction

	always @(negedge i_sda) begin
		if (i_scl) begin
			starts++;
			bitn = -1;
			first = 1;
			rd = 0;
		end
	end

	always @(posedge i_sda) begin
		if (i_scl) begin
			stops++;
			rd_idx = 0;
		end
	end

	always @(posedge i_scl) begin
		if (bitn == 0) t0 = $time;
		if (bitn == 1) per = $time - t0;
		if (bitn < 8) sh = {sh[6:0], i_sda};
		else if (rd && !first) begin
			ack_q.push_back(i_sda);
			// a refused byte ends our turn as sender
			if (i_sda) rd = 0;
		end
	end

	always @(negedge i_scl) begin
		if (bitn == 8) begin
			bitn = 0;
			first = 0;
		end else begin
			bitn++;
		end
		cur = RD_BASE + 8'(rd_idx);
		if (bitn == 8) begin
			if (first) rd = sh[0];
			// acknowledge what we receive, leave the line for the master otherwise
			o_sda_oe_n = rd && !first;
			if (rd && !first) rd_idx++;
			else log_q.push_back(sh);
		end else begin
			o_sda_oe_n = rd ? cur[7 - bitn] : 1'b1;
		end
	end
endmodule
`default_nettype wire

// ---- tb/test_buffered_i2c_master_engine.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_buffered_i2c_master_engine;
	import i2c_engine_pkg::*;
	localparam logic [7:0] RD_BASE = 8'hA0;
	localparam int         LIMIT   = 30000;
	logic       clk  = 0;
	logic       rst  = 1;
	logic [7:0] div  = MIN_DIVIDER;
	logic       pair = 0;
	logic       ten  = 0;
	logic       dir1 = 0;
	logic       rs   = 0;
	logic       dir2 = 0;
	logic       stp  = 1;
	logic       trig = 0;
	logic [4:0] len1 = 0;
	logic [4:0] len2 = 0;
	logic [9:0] addr = 0;
	logic       txw  = 0;
	logic       txl  = 0;
	logic [7:0] txd  = 0;
	logic [3:0] txp  = 0;
	logic [3:0] rxp  = 0;
	logic [7:0] rxd;
	logic       txrdy, done, paused, attn;
	logic [1:0] scl_oe_n, sda_oe_n, scl_w, sda_w;
	wire  [1:0] slv_oe_n;
	int         n_fail = 0;
	int         cmp_count = 0;
	int         cyc = 0;
	int         n_attn = 0;
	logic [7:0] e[$];

	always #50 clk = ~clk;
	// pull-ups: anything not pulling low reads high
	assign scl_w = {scl_oe_n[1] !== 1'b0, scl_oe_n[0] !== 1'b0};
	assign sda_w = {sda_oe_n[1] !== 1'b0 && slv_oe_n[1] !== 1'b0, sda_oe_n[0] !== 1'b0 && slv_oe_n[0] !== 1'b0};

	buffered_i2c_master_engine buffered_i2c_master_engine_inst (
		.i_clk_sys(clk), .i_rst(rst), .i_scl_divider_count(div), .i_pin_pair_select(pair),
		.i_ten_bit_address_select(ten), .i_first_burst_length(len1), .i_first_burst_direction(dir1),
		.i_repeated_start_enable(rs), .i_second_burst_length(len2), .i_second_burst_direction(dir2),
		.i_stop_enable(stp), .i_target_address_trigger(trig), .i_target_address(addr),
		.i_tx_buffer_write(txw), .i_tx_buffer_pointer_load(txl), .i_tx_buffer_pointer(txp),
		.i_tx_buffer_data(txd), .o_tx_buffer_ready(txrdy), .i_rx_buffer_pointer(rxp),
		.o_rx_buffer_data(rxd), .o_transaction_complete_flag(done), .o_paused_waiting_flag(paused),
		.o_attention_pulse(attn), .i_scl_in(scl_w), .i_sda_in(sda_w), .o_scl_out(),
		.o_scl_oe_n(scl_oe_n), .o_sda_out(), .o_sda_oe_n(sda_oe_n));
	i2c_target_model slv0 (.i_scl(scl_w[0]), .i_sda(sda_w[0]), .o_sda_oe_n(slv_oe_n[0]));
	i2c_target_model slv1 (.i_scl(scl_w[1]), .i_sda(sda_w[1]), .o_sda_oe_n(slv_oe_n[1]));

	task automatic step();
		@(posedge clk);
		#10;
	endtask

	task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %0h seen %0h", what, exp, got);
		end
	endtask

	task automatic conclude();
		if (n_fail == 0 && cmp_count > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask

	task automatic push(input logic ld, input logic [3:0] p, input logic [7:0] d);
		txw = 1;
		txl = ld;
		txp = p;
		txd = d;
		step();
	endtask

	task automatic kick();
		trig = 1;
		step();
		trig = 0;
		chk("busy after trigger", done | paused, 0);
	endtask

	// host sets pair, address, lengths and directions here, only after complete; divider and stop are set outside
	task automatic go(input logic p, input logic t, input logic [9:0] a, input logic [4:0] l1,
			input logic d1, input logic r, input logic [4:0] l2, input logic d2);
		pair = p;
		ten = t;
		addr = a;
		len1 = l1;
		dir1 = d1;
		rs = r;
		len2 = l2;
		dir2 = d2;
		slv0.clear();
		slv1.clear();
		kick();
	endtask

	task automatic wait_end();
		for (int i = 0; i < 9000 && done !== 1'b1 && paused !== 1'b1; i++)
			step();
	endtask

	task automatic bus(input logic p, input int ns);
		chk("bus bytes", 16'(p ? slv1.log_q.size() : slv0.log_q.size()), 16'(e.size()));
		foreach (e[i]) chk("bus byte", p ? slv1.log_q[i] : slv0.log_q[i], e[i]);
		chk("starts", 16'(p ? slv1.starts : slv0.starts), 16'(ns));
		chk("stops", 16'(p ? slv1.stops : slv0.stops), 1);
		chk("idle pair starts", 16'(p ? slv0.starts : slv1.starts), 0);
	endtask

	task automatic rx(input int n, input logic [7:0] b);
		for (int i = 0; i < n; i++) begin
			rxp = 4'(i);
			step();
			chk("rx byte", rxd, b + 8'(i));
		end
	endtask

	// counted mid-cycle so the registered pulse is settled when looked at
	always @(negedge clk) begin
		cyc++;
		if (attn === 1'b1) n_attn++;
		if (cyc == LIMIT) begin
			n_fail++;
			conclude();
		end
	end

	initial begin
		repeat (12) step();
		rst = 0;
		chk("complete at reset", done, 1);
		chk("paused at reset", paused, 0);
		push(1, 4'h0, 8'h11);
		push(1, 4'h2, 8'h33);
		push(1, 4'h1, 8'h22);
		txw = 0;
		// queue drains one entry a cycle while idle
		repeat (FIFO_DEPTH + 2) step();
		div = 8'(FAST_DIVIDER);
		go(0, 0, 10'h052, 3, 0, 0, 0, 0);
		wait_end();
		e = '{8'hA4, 8'h11, 8'h22, 8'h33};
		bus(0, 1);
		chk("fast scl period", 16'(slv0.per), 16'(400 * FAST_DIVIDER));
		div = 8'(STD_DIVIDER);
		go(1, 0, 10'h029, 4, 1, 0, 0, 0);
		for (int i = 0; i < FIFO_DEPTH; i++) push(1'(i == 0), PTR_ZERO, 8'h30 + 8'(i));
		txw = 0;
		chk("queue full while busy", txrdy, 0);
		wait_end();
		e = '{8'h53};
		bus(1, 1);
		chk("std scl period", 16'(slv1.per), 16'(400 * STD_DIVIDER));
		rx(4, RD_BASE);
		chk("ack first", slv1.ack_q[0], 0);
		chk("nack last", slv1.ack_q[3], 1);
		repeat (FIFO_DEPTH + 2) step();
		chk("queue drained", txrdy, 1);
		div = MIN_DIVIDER;
		go(0, 1, 10'h2A5, 3, 0, 0, 0, 0);
		wait_end();
		e = '{8'hF4, 8'hA5, 8'h30, 8'h31, 8'h32};
		bus(0, 1);
		go(1, 0, 10'h029, 2, 0, 1, 2, 1);
		wait_end();
		e = '{8'h52, 8'h30, 8'h31, 8'h53};
		bus(1, 2);
		rx(2, RD_BASE);
		go(0, 0, 10'h052, 2, 1, 1, 3, 1);
		wait_end();
		rx(5, RD_BASE);
		chk("nack before restart", slv0.ack_q[1], 1);
		stp = 0;
		go(0, 0, 10'h052, 20, 1, 0, 0, 0);
		wait_end();
		chk("paused", paused, 1);
		chk("no stop while paused", 16'(slv0.stops), 0);
		rx(16, RD_BASE);
		stp = 1;
		kick();
		wait_end();
		chk("complete after last block", done, 1);
		chk("single start", 16'(slv0.starts), 1);
		rx(4, RD_BASE + 8'h10);
		chk("attention count", 16'(n_attn), 7);
		conclude();
	end
endmodule
`default_nettype wire
